// ==== rtl/cpu_exec.sv ====
// Execution engine for immediate, internal register, branch, jump and
// extended operation instructions of a workspace-register processor.
// Assumes a word memory that acknowledges each held request with one pulse.
// Summary of operation
// - Add immediate to register, flags 0-4
// - AND immediate into register, flags 0-2
// - Compare register to immediate, no write
// - Equal compare sets equal flag
// - Load immediate into register, flags 0-2
// - OR immediate into register, flags 0-2
// - Load workspace base, flags untouched
// - Immediate bits 12-15 into mask flags
// - Store instructions leave flags untouched
// - Store flag word into named register
// - Store workspace base into named register
// - Decode extended operation fields and source
// - Extended operation sets flag 6
// - Vector words at 0x40+4D and 0x42+4D
// - Save old base, counter, flags R13-R15
// - Source address saved in new R11
// - No interrupt check after extended operation
// - Relative jump within +127/-128 words
// - Two-word branch reaches any address
// - Branch and link saves return in R11
// - New-workspace branch saves old context
// - Mask flags gate interrupt acceptance
`timescale 1ns/100ps
`default_nettype none
module cpu_exec
  import cpu_exec_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_srst,
  input  wire logic       i_interrupt_request_n,
  input  wire logic [3:0] i_interrupt_level,
  input  wire logic       i_mem_ack,
  input  wire word_t      i_mem_rdata,
  output logic            o_mem_req,
  output logic            o_mem_we,
  output word_t           o_mem_addr,
  output word_t           o_mem_wdata,
  output logic            o_int_ack,
  output word_t           o_program_counter,
  output word_t           o_workspace,
  output word_t           o_flag_word
);

  exec_regs_t r_r;
  exec_regs_t r_nxt;
  logic       done;
  logic       int_pend;
  logic [3:0] rfield;
  logic [1:0] ts;
  word_t      alu_res;
  alu_flags_t alu_f;
  alu_op_t    alu_op;

  function automatic word_t reg_addr(word_t base, logic [3:0] idx);
    return 16'(base + {11'h000, idx, 1'b0});
  endfunction

  function automatic mem_req_t rd(word_t a);
    return '{req: 1'b1, we: 1'b0, addr: a, wdata: '0};
  endfunction

  function automatic mem_req_t wr(word_t a, word_t d);
    return '{req: 1'b1, we: 1'b1, addr: a, wdata: d};
  endfunction

  assign rfield = r_r.ir[3:0];
  assign ts     = r_r.ir[5:4];
  assign done   = r_r.mem.req && i_mem_ack;
  // The request level is active low; both the level and the request share the filter.
  assign int_pend = ~r_r.stable[4];

  always_comb begin
    case (r_r.ir[15:5])
      OP_AI:   alu_op = ALU_ADD;
      OP_AND_IMMEDIATE: alu_op = ALU_AND;
      OP_ORI:  alu_op = ALU_OR;
      OP_CI:   alu_op = ALU_CMP;
      default: alu_op = ALU_LOAD;
    endcase
  end

  cpu_imm_alu u_alu (
    .i_op     (alu_op),
    .i_a      (r_r.opa),
    .i_b      (r_r.immediate_operand),
    .o_result (alu_res),
    .o_flags  (alu_f)
  );

  // ==========================================================================
  // Next-state logic.
  always_comb begin
    r_nxt = r_r;
    r_nxt.mem.req = 1'b0;
    r_nxt.int_ack = 1'b0;
    r_nxt.sync1 = {i_interrupt_request_n, i_interrupt_level};
    r_nxt.sync2 = r_r.sync1;
    r_nxt.sync3 = r_r.sync2;
    if (r_r.sync2 == r_r.sync3) begin
      r_nxt.stable = r_r.sync3;
    end
    case (r_r.state)
      S_CHECK: begin
        r_nxt.skip_int = 1'b0;
        r_nxt.state    = S_FETCH;
        // Lower level numbers are more urgent; the mask admits levels up to its value.
        if (!r_r.skip_int && int_pend && (r_r.stable[3:0] <= r_r.st[3:0])) begin
          r_nxt.vec     = 16'(INT_VEC_BASE + {10'h000, r_r.stable[3:0], 2'b00});
          r_nxt.is_xop  = 1'b0;
          r_nxt.is_int  = 1'b1;
          r_nxt.int_ack = 1'b1;
          r_nxt.state   = S_VEC_WP;
        end
      end
      S_FETCH: begin
        r_nxt.mem = rd(r_r.pc);
        if (done) begin
          r_nxt.ir    = i_mem_rdata;
          r_nxt.pc    = 16'(r_r.pc + WORD_STEP);
          r_nxt.state = S_DECODE;
        end
      end
      S_DECODE: begin
        r_nxt.is_xop = 1'b0;
        r_nxt.is_int = 1'b0;
        r_nxt.state  = S_CHECK;
        case (r_r.ir[15:5])
          OP_LI, OP_AI, OP_AND_IMMEDIATE, OP_ORI, OP_CI, OP_LOAD_WORKSPACE_IMMEDIATE, OP_LOAD_INTERRUPT_MASK: begin
            r_nxt.state = S_IMM;
          end
          OP_SAVE_WORKSPACE_TO_REG: begin
            r_nxt.tmp   = r_r.wp;
            r_nxt.state = S_STORE;
          end
          OP_SAVE_FLAGS_TO_REG: begin
            r_nxt.tmp   = r_r.st;
            r_nxt.state = S_STORE;
          end
          default: begin
            if (r_r.ir[15:10] == OP_XOP) begin
              r_nxt.is_xop = 1'b1;
              r_nxt.state  = S_SRC;
            end else if (r_r.ir[15:6] == OP_B || r_r.ir[15:6] == OP_BL ||
                         r_r.ir[15:6] == OP_BRANCH_NEW_WORKSPACE) begin
              r_nxt.state = S_SRC;
            end else if (r_r.ir[15:8] == OP_JMP) begin
              // The counter already points past the jump word.
              r_nxt.pc = 16'(r_r.pc + {{7{r_r.ir[7]}}, r_r.ir[7:0], 1'b0});
            end
          end
        endcase
      end
      S_IMM: begin
        r_nxt.mem = rd(r_r.pc);
        if (done) begin
          r_nxt.immediate_operand   = i_mem_rdata;
          r_nxt.pc    = 16'(r_r.pc + WORD_STEP);
          r_nxt.state = S_RD_R;
          if (r_r.ir[15:5] == OP_LOAD_WORKSPACE_IMMEDIATE) begin
            r_nxt.wp    = i_mem_rdata;
            r_nxt.state = S_CHECK;
          end else if (r_r.ir[15:5] == OP_LOAD_INTERRUPT_MASK) begin
            r_nxt.st[3:0] = i_mem_rdata[3:0];
            r_nxt.state   = S_CHECK;
          end else if (r_r.ir[15:5] == OP_LI) begin
            r_nxt.state = S_ALU;
          end
        end
      end
      S_RD_R: begin
        r_nxt.mem = rd(reg_addr(r_r.wp, rfield));
        if (done) begin
          r_nxt.opa   = i_mem_rdata;
          r_nxt.state = S_ALU;
        end
      end
      S_ALU: begin
        r_nxt.st[ST_LGT] = alu_f.lgt;
        r_nxt.st[ST_AGT] = alu_f.agt;
        r_nxt.st[ST_EQ]  = alu_f.eq;
        if (alu_op == ALU_ADD) begin
          r_nxt.st[ST_C]  = alu_f.carry;
          r_nxt.st[ST_OV] = alu_f.ovf;
        end
        r_nxt.tmp   = alu_res;
        r_nxt.state = (alu_op == ALU_CMP) ? S_CHECK : S_STORE;
      end
      S_STORE: begin
        r_nxt.mem = wr(reg_addr(r_r.wp, rfield), r_r.tmp);
        if (done) begin
          r_nxt.state = S_CHECK;
        end
      end
      S_SRC: begin
        case (ts)
          TS_REG: begin
            r_nxt.sa    = reg_addr(r_r.wp, rfield);
            r_nxt.state = S_EXEC;
          end
          TS_SYM:  r_nxt.state = S_RD_SYM;
          default: r_nxt.state = S_RD_RS;
        endcase
      end
      S_RD_RS: begin
        r_nxt.mem = rd(reg_addr(r_r.wp, rfield));
        if (done) begin
          r_nxt.sa    = i_mem_rdata;
          r_nxt.tmp   = 16'(i_mem_rdata + WORD_STEP);
          r_nxt.state = (ts == TS_INC) ? S_AUTOINC : S_EXEC;
        end
      end
      S_AUTOINC: begin
        r_nxt.mem = wr(reg_addr(r_r.wp, rfield), r_r.tmp);
        if (done) begin
          r_nxt.state = S_EXEC;
        end
      end
      S_RD_SYM: begin
        r_nxt.mem = rd(r_r.pc);
        if (done) begin
          r_nxt.sa    = i_mem_rdata;
          r_nxt.pc    = 16'(r_r.pc + WORD_STEP);
          r_nxt.state = (rfield != '0) ? S_RD_IDX : S_EXEC;
        end
      end
      S_RD_IDX: begin
        r_nxt.mem = rd(reg_addr(r_r.wp, rfield));
        if (done) begin
          r_nxt.sa    = 16'(r_r.sa + i_mem_rdata);
          r_nxt.state = S_EXEC;
        end
      end
      S_EXEC: begin
        r_nxt.state = S_CHECK;
        if (r_r.is_xop) begin
          r_nxt.vec   = 16'(XOP_VEC_BASE + {10'h000, r_r.ir[9:6], 2'b00});
          r_nxt.state = S_VEC_WP;
        end else if (r_r.ir[15:6] == OP_B) begin
          r_nxt.pc = r_r.sa;
        end else if (r_r.ir[15:6] == OP_BL) begin
          r_nxt.state = S_LINK;
        end else begin
          r_nxt.vec   = r_r.sa;
          r_nxt.state = S_VEC_WP;
        end
      end
      S_LINK: begin
        r_nxt.mem = wr(reg_addr(r_r.wp, REG_LINK), r_r.pc);
        if (done) begin
          r_nxt.pc    = r_r.sa;
          r_nxt.state = S_CHECK;
        end
      end
      S_VEC_WP: begin
        r_nxt.mem = rd(r_r.vec);
        if (done) begin
          r_nxt.tmp   = i_mem_rdata;
          r_nxt.state = S_VEC_PC;
        end
      end
      S_VEC_PC: begin
        r_nxt.mem = rd(16'(r_r.vec + WORD_STEP));
        if (done) begin
          r_nxt.npc   = i_mem_rdata;
          r_nxt.state = S_SV13;
        end
      end
      S_SV13: begin
        r_nxt.mem = wr(reg_addr(r_r.tmp, REG_OLD_WP), r_r.wp);
        if (done) begin
          r_nxt.state = S_SV14;
        end
      end
      S_SV14: begin
        r_nxt.mem = wr(reg_addr(r_r.tmp, REG_OLD_PC), r_r.pc);
        if (done) begin
          r_nxt.state = S_SV15;
        end
      end
      S_SV15: begin
        r_nxt.mem = wr(reg_addr(r_r.tmp, REG_OLD_ST), r_r.st);
        if (done) begin
          r_nxt.state = r_r.is_xop ? S_SV11 : S_SWITCH;
        end
      end
      S_SV11: begin
        r_nxt.mem = wr(reg_addr(r_r.tmp, REG_LINK), r_r.sa);
        if (done) begin
          r_nxt.state = S_SWITCH;
        end
      end
      S_SWITCH: begin
        r_nxt.wp       = r_r.tmp;
        r_nxt.pc       = r_r.npc;
        r_nxt.st[ST_X] = r_r.is_xop ? 1'b1 : r_r.st[ST_X];
        // Interrupt entry may chain; software switches get one instruction first.
        r_nxt.skip_int = ~r_r.is_int;
        r_nxt.state    = S_CHECK;
      end
      default: r_nxt.state = S_CHECK;
    endcase
    if (done) begin
      r_nxt.mem.req = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      r_r       <= '0;
      r_r.state <= S_CHECK;
      r_r.pc    <= RESET_PC;
      r_r.wp    <= RESET_WP;
      r_r.st    <= RESET_ST;
      r_r.stable <= 5'h1F;
      r_r.sync1 <= 5'h1F;
      r_r.sync2 <= 5'h1F;
      r_r.sync3 <= 5'h1F;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign o_mem_req         = r_r.mem.req;
  assign o_mem_we          = r_r.mem.we;
  assign o_mem_addr        = r_r.mem.addr;
  assign o_mem_wdata       = r_r.mem.wdata;
  assign o_int_ack         = r_r.int_ack;
  assign o_program_counter = r_r.pc;
  assign o_workspace       = r_r.wp;
  assign o_flag_word       = r_r.st;

  // ==========================================================================
  // Assertions and covers.
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  a_ai_sum_store: assert property ((r_r.state == S_ALU && alu_op == ALU_ADD) |=>
    (r_r.state == S_STORE && r_r.tmp == 16'($past(r_r.opa) + $past(r_r.immediate_operand))))
    else $error("add immediate result wrong");
  a_and_immediate_zero_flag: assert property ((r_r.state == S_ALU && alu_op == ALU_AND) |=>
    (r_r.tmp == ($past(r_r.opa) & $past(r_r.immediate_operand)) && r_r.st[ST_EQ] == (r_r.tmp == '0)))
    else $error("and immediate result or flag wrong");
  a_ci_no_write: assert property ((r_r.state == S_ALU && alu_op == ALU_CMP) |=>
    (r_r.state == S_CHECK ##1 !o_mem_we))
    else $error("compare immediate wrote a register");
  a_ci_equal_flag: assert property ((r_r.state == S_ALU && alu_op == ALU_CMP &&
    r_r.opa == r_r.immediate_operand) |=> r_r.st[ST_EQ])
    else $error("compare equal flag not set");
  a_load_workspace_immediate_flags_kept: assert property ((r_r.state == S_IMM && done &&
    r_r.ir[15:5] == OP_LOAD_WORKSPACE_IMMEDIATE) |=> (r_r.wp == $past(i_mem_rdata) && $stable(r_r.st)))
    else $error("workspace load wrong or flags changed");
  a_load_interrupt_mask_mask_only: assert property ((r_r.state == S_IMM && done &&
    r_r.ir[15:5] == OP_LOAD_INTERRUPT_MASK) |=> (r_r.st[3:0] == $past(i_mem_rdata[3:0]) &&
    r_r.st[15:4] == $past(r_r.st[15:4])))
    else $error("mask load wrong");
  a_store_flags_kept: assert property ((r_r.state == S_DECODE &&
    (r_r.ir[15:5] == OP_SAVE_FLAGS_TO_REG || r_r.ir[15:5] == OP_SAVE_WORKSPACE_TO_REG)) |=> $stable(r_r.st) [*2])
    else $error("store changed flags");
  a_xop_vector_addr: assert property ((r_r.state == S_VEC_WP && r_r.is_xop && o_mem_req)
    |-> o_mem_addr == 16'(XOP_VEC_BASE + {10'h000, r_r.ir[9:6], 2'b00}))
    else $error("extended operation vector address wrong");
  a_xop_sets_flag6: assert property ((r_r.state == S_SWITCH && r_r.is_xop) |=>
    (r_r.st[ST_X] && r_r.wp == $past(r_r.tmp)))
    else $error("extended operation flag not set");
  a_xop_int_skipped: assert property ((r_r.state == S_SWITCH && r_r.is_xop) |=>
    (r_r.state == S_CHECK ##1 (r_r.state == S_FETCH && !o_int_ack)))
    else $error("interrupt taken right after extended operation");
  a_jmp_target: assert property ((r_r.state == S_DECODE && r_r.ir[15:8] == OP_JMP) |=>
    r_r.pc == 16'($past(r_r.pc) + {{7{$past(r_r.ir[7])}}, $past(r_r.ir[7:0]), 1'b0}))
    else $error("jump target wrong");
  a_req_held: assert property ((o_mem_req && !i_mem_ack) |=>
    (o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we)))
    else $error("memory request dropped before acknowledge");

  c_xop_switch: cover property (r_r.state == S_SWITCH && r_r.is_xop);
  c_int_taken: cover property (o_int_ack);
  c_ci_equal: cover property (r_r.state == S_ALU && alu_op == ALU_CMP && alu_f.eq);
  c_bl_link: cover property (r_r.state == S_LINK && done);

endmodule
`default_nettype wire

// ==== rtl/cpu_exec_pkg.sv ====
// Constants, opcodes, status bit positions and state types for the
// immediate, internal register and context switch execution engine.
// Assumes a word-wide memory port with byte addresses, returning a one-cycle acknowledge.
package cpu_exec_pkg;

  typedef logic [15:0] word_t;

  // ==========================================================================
  // Opcodes, compared against the leading bits of the first instruction word.
  localparam logic [10:0] OP_LI   = 11'h010;
  localparam logic [10:0] OP_AI   = 11'h011;
  localparam logic [10:0] OP_AND_IMMEDIATE = 11'h012;
  localparam logic [10:0] OP_ORI  = 11'h013;
  localparam logic [10:0] OP_CI   = 11'h014;
  localparam logic [10:0] OP_SAVE_WORKSPACE_TO_REG = 11'h015;
  localparam logic [10:0] OP_SAVE_FLAGS_TO_REG = 11'h016;
  localparam logic [10:0] OP_LOAD_WORKSPACE_IMMEDIATE = 11'h017;
  localparam logic [10:0] OP_LOAD_INTERRUPT_MASK = 11'h018;
  localparam logic [9:0]  OP_BRANCH_NEW_WORKSPACE = 10'h010;
  localparam logic [9:0]  OP_B    = 10'h011;
  localparam logic [9:0]  OP_BL   = 10'h01A;
  localparam logic [5:0]  OP_XOP  = 6'h0B;
  localparam logic [7:0]  OP_JMP  = 8'h10;

  // ==========================================================================
  // Flag word bit positions; leftmost bit of the word is flag 0.
  localparam int ST_LGT = 15;
  localparam int ST_AGT = 14;
  localparam int ST_EQ  = 13;
  localparam int ST_C   = 12;
  localparam int ST_OV  = 11;
  localparam int ST_X   = 9;

  // ==========================================================================
  // Addresses, register indices and addressing modes.
  localparam word_t      XOP_VEC_BASE = 16'h0040;
  localparam word_t      INT_VEC_BASE = 16'h0000;
  localparam word_t      WORD_STEP    = 16'h0002;
  localparam word_t      RESET_PC     = 16'h0000;
  localparam word_t      RESET_WP     = 16'h0000;
  localparam word_t      RESET_ST     = 16'h0000;
  localparam logic [3:0] REG_LINK     = 4'hB;
  localparam logic [3:0] REG_OLD_WP   = 4'hD;
  localparam logic [3:0] REG_OLD_PC   = 4'hE;
  localparam logic [3:0] REG_OLD_ST   = 4'hF;
  localparam logic [1:0] TS_REG       = 2'h0;
  localparam logic [1:0] TS_IND       = 2'h1;
  localparam logic [1:0] TS_SYM       = 2'h2;
  localparam logic [1:0] TS_INC       = 2'h3;

  typedef enum logic [2:0] {ALU_LOAD, ALU_ADD, ALU_AND, ALU_OR, ALU_CMP} alu_op_t;

  typedef struct packed {
    logic lgt;
    logic agt;
    logic eq;
    logic carry;
    logic ovf;
  } alu_flags_t;

  typedef struct packed {
    logic  req;
    logic  we;
    word_t addr;
    word_t wdata;
  } mem_req_t;

  typedef enum logic [4:0] {
    S_CHECK, S_FETCH, S_DECODE, S_IMM, S_RD_R, S_ALU, S_STORE,
    S_SRC, S_RD_RS, S_AUTOINC, S_RD_SYM, S_RD_IDX, S_EXEC, S_LINK,
    S_VEC_WP, S_VEC_PC, S_SV13, S_SV14, S_SV15, S_SV11, S_SWITCH
  } exec_state_t;

  typedef struct packed {
    exec_state_t state;
    mem_req_t    mem;
    word_t       ir;
    word_t       pc;
    word_t       wp;
    word_t       st;
    word_t       immediate_operand;
    word_t       opa;
    word_t       tmp;
    word_t       npc;
    word_t       sa;
    word_t       vec;
    logic        is_xop;
    logic        is_int;
    logic        skip_int;
    logic        int_ack;
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    logic [4:0]  sync3;
    logic [4:0]  stable;
  } exec_regs_t;

endpackage

// ==== rtl/cpu_imm_alu.sv ====
// Combinational result and compare flags for the immediate instructions.
// Assumes the caller chooses which flag bits it commits.
`timescale 1ns/100ps
`default_nettype none
module cpu_imm_alu
  import cpu_exec_pkg::*;
(
  input  wire alu_op_t    i_op,
  input  wire word_t      i_a,
  input  wire word_t      i_b,
  output var  word_t      o_result,
  output var  alu_flags_t o_flags
);

  logic [16:0] sum;
  word_t       cmp_l;
  word_t       cmp_r;

  always_comb begin
    sum = {1'b0, i_a} + {1'b0, i_b};
    case (i_op)
      ALU_ADD: o_result = sum[15:0];
      ALU_AND: o_result = i_a & i_b;
      ALU_OR:  o_result = i_a | i_b;
      ALU_CMP: o_result = i_a;
      default: o_result = i_b;
    endcase
    // A compare sets flags from both operands; every other operation compares its result to zero.
    cmp_l = (i_op == ALU_CMP) ? i_a : o_result;
    cmp_r = (i_op == ALU_CMP) ? i_b : '0;
    o_flags.lgt   = cmp_l > cmp_r;
    o_flags.agt   = $signed(cmp_l) > $signed(cmp_r);
    o_flags.eq    = cmp_l == cmp_r;
    o_flags.carry = sum[16];
    o_flags.ovf   = (i_a[15] == i_b[15]) && (sum[15] != i_a[15]);
  end

endmodule
`default_nettype wire

// ==== tb/mem_model.sv ====
// Word memory partner for the execution engine, with a varying acknowledge delay.
// Assumes the engine holds each request until it samples the acknowledge.
`timescale 1ns/100ps
`default_nettype none
module mem_model
  import cpu_exec_pkg::*;
(
  input  wire logic  i_clk,
  input  wire logic  i_slow,
  input  wire logic  i_req,
  input  wire logic  i_we,
  input  wire word_t i_addr,
  input  wire word_t i_wdata,
  output logic       o_ack,
  output word_t      o_rdata
);
  // ==========================================================================
  // Storage; the bench preloads it with code and call vectors.
  word_t      mem_r [0:511];
  word_t      rd_r;
  logic [1:0] wait_r;
  // Outside the answer cycle the bus shows the inverse word, so a stray sample never matches.
  assign o_rdata = o_ack ? rd_r : ~rd_r;
  initial begin
    o_ack  = 1'b0;
    rd_r   = 16'h0000;
    wait_r = 2'h0;
  end
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    if (i_req && !o_ack) begin
      if (wait_r == 2'h0) begin
        o_ack  <= 1'b1;
        rd_r   <= mem_r[i_addr[9:1]];
        wait_r <= i_slow ? 2'h3 : 2'h0;
        if (i_we) begin
          mem_r[i_addr[9:1]] <= i_wdata;
        end
      end else begin
        wait_r <= wait_r - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Runs a short program through the engine and compares every memory write.
// Assumes reset starts execution at address 0 with a zero workspace.
`timescale 1ns/100ps
`default_nettype none
module testbench
  import cpu_exec_pkg::*;
  ;
  logic  i_mclk;
  logic  i_srst;
  logic  irq_n;
  logic  [3:0] irq_level;
  word_t pc_seen;
  word_t flags_seen;
  logic  slow;
  logic  ack;
  logic  req;
  logic  we;
  logic  int_ack;
  logic  xop_saved;
  logic  carry;
  word_t rdata;
  word_t addr;
  word_t wdata;
  word_t wp;
  word_t v;
  word_t sum;
  word_t st1;
  word_t st2;
  word_t st3;
  word_t exp_a [$];
  word_t exp_d [$];
  word_t img [0:57];
  word_t wr [0:31];
  int    num_errors;
  int    num_checks;
  int    cycles;
  int    int_acks;
  int    seed;

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  cpu_exec dut (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_interrupt_request_n(irq_n),
    .i_interrupt_level(irq_level), .i_mem_ack(ack), .i_mem_rdata(rdata),
    .o_mem_req(req), .o_mem_we(we), .o_mem_addr(addr), .o_mem_wdata(wdata),
    .o_int_ack(int_ack), .o_program_counter(pc_seen), .o_workspace(wp),
    .o_flag_word(flags_seen)
  );
  mem_model u_mem (
    .i_clk(i_mclk), .i_slow(slow), .i_req(req), .i_we(we), .i_addr(addr),
    .i_wdata(wdata), .o_ack(ack), .o_rdata(rdata)
  );

  task automatic check(input word_t seen, input word_t expd);
    num_checks++;
    if (seen !== expd) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Result watcher: each acknowledged write takes the oldest note.
  always @(posedge i_mclk) begin
    cycles++;
    if (int_ack === 1'b1) begin
      int_acks++;
    end
    if (req === 1'b1 && we === 1'b1 && ack === 1'b1) begin
      if (addr === 16'h015A) begin
        xop_saved = 1'b1;
      end
      if (exp_a.size() == 0) begin
        check(addr, ~addr);
      end else begin
        check(addr, exp_a.pop_front());
        check(wdata, exp_d.pop_front());
      end
    end
    if (cycles == 4000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // The request stands from the start at a masked level, so the mask must refuse it.
  // Once the call has begun saving, the level drops to one the mask admits.
  always @(negedge i_mclk) begin
    slow <= ($random(seed) & 1) != 0;
    if (int_acks != 0) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= 1'b0;
    end
    irq_level <= xop_saved ? 4'h2 : 4'hF;
  end

  initial begin
    seed = 25;
    num_errors = 0;
    num_checks = 0;
    cycles = 0;
    int_acks = 0;
    xop_saved = 1'b0;
    i_srst = 1'b1;
    irq_n = 1'b1;
    irq_level = 4'hF;
    slow = 1'b0;
    v = word_t'($random(seed));
    {carry, sum} = {1'b0, v} + 17'h000FF;
    st1 = 16'h0000;
    st1[ST_EQ] = 1'b1;
    st1[ST_C] = carry;
    st1[ST_OV] = ~v[15] & sum[15];
    st2 = st1;
    st2[ST_EQ] = 1'b0;
    st2[ST_LGT] = 1'b1;
    st2[ST_AGT] = 1'b1;
    st2[3:0] = 4'hA;
    st3 = st2;
    st3[ST_X] = 1'b1;
    // Address and word pairs: code, interrupt vector and call vector 3.
    img = '{16'h0000, 16'h0460, 16'h0002, 16'h0080, 16'h0008, 16'h01C0, 16'h000A, 16'h00C0,
            16'h004C, 16'h0140, 16'h004E, 16'h01A0, 16'h0080, 16'h02E0, 16'h0082, 16'h0100,
            16'h0084, 16'h0202, 16'h0086, v, 16'h0088, 16'h0222, 16'h008A, 16'h00FF,
            16'h008C, 16'h0282, 16'h008E, sum, 16'h0090, 16'h02C3, 16'h0092, 16'h0242,
            16'h0094, 16'h0F0F, 16'h0096, 16'h0262, 16'h0098, 16'h3000, 16'h009A, 16'h0300,
            16'h009C, 16'h000A, 16'h009E, 16'h02A4, 16'h00A0, 16'h02C5, 16'h00A2, 16'h2CE0,
            16'h00A4, 16'h0180, 16'h01A0, 16'h02C6, 16'h00C0, 16'h06A0, 16'h00C2, 16'h00D0,
            16'h00D0, 16'h10FF};
    wr = '{16'h0104, v, 16'h0104, sum, 16'h0106, st1, 16'h0104, sum & 16'h0F0F,
           16'h0104, (sum & 16'h0F0F) | 16'h3000, 16'h0108, 16'h0100, 16'h010A, st2,
           16'h015A, 16'h0100, 16'h015C, 16'h00A6, 16'h015E, st2, 16'h0156, 16'h0180,
           16'h014C, st3, 16'h01DA, 16'h0140, 16'h01DC, 16'h01A2, 16'h01DE, st3,
           16'h01D6, 16'h00C4};
    for (int i = 0; i < 29; i++) begin
      u_mem.mem_r[img[2*i][9:1]] = img[2*i+1];
    end
    for (int i = 0; i < 16; i++) begin
      exp_a.push_back(wr[2*i]);
      exp_d.push_back(wr[2*i+1]);
    end
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    i_srst = 1'b0;
    for (int i = 0; i < 3000 && exp_a.size() != 0; i++) begin
      @(posedge i_mclk);
    end
    repeat (10) @(posedge i_mclk);
    check(word_t'(exp_a.size()), 16'h0000);
    check(word_t'(int_acks), 16'h0001);
    check(wp, 16'h01C0);
    check(flags_seen, st3);
    check({pc_seen[15:2], 2'b00}, 16'h00D0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
